/* File: logic/sram_port_consts.svh */
// Constants for the pipelined burst memory port: widths, reset values, depths.
// Assumes inclusion by bare name from the package and the port module.
`ifndef SRAM_PORT_CONSTS_SVH
`define SRAM_PORT_CONSTS_SVH

`define SP_ADDR_W      18
`define SP_LANES       4
`define SP_LANE_W      9
`define SP_BYTE_W      8
`define SP_ALL_LANES   4'hf
`define SP_NO_LANES    4'h0
`define SP_LOW_W       2
`define SP_LOW_ZERO    2'h0
`define SP_LOW_ONE     2'h1
`define SP_STRAP_RST   1'b1
`define SP_FIFO_DEPTH  32

`endif

/* File: logic/sram_port_pkg.sv */
// Types shared by the memory port and its write buffer.
// Assumes sram_port_consts.svh is on the include path.
`include "sram_port_consts.svh"

package sram_port_pkg;

    typedef logic [`SP_LANES*`SP_LANE_W-1:0] word_t;
    typedef logic [`SP_ADDR_W-1:0]           addr_t;
    typedef logic [`SP_LANES-1:0]            lanes_t;

    typedef enum logic {
        ORDER_LINEAR,
        ORDER_INTERLEAVED
    } burst_order_e;

    // One pending array write: address, lanes to update, captured data
    typedef struct packed {
        addr_t  addr;
        lanes_t lanes;
        word_t  data;
    } wr_entry_s;

    // Write request formed in the cycle its controls are sampled
    typedef struct packed {
        logic   valid;
        addr_t  addr;
        lanes_t lanes;
    } wr_pend_s;

endpackage : sram_port_pkg

/* File: logic/word_fifo.sv */
// Buffer of words with valid/ready on both sides; head word held in a register.
// Assumes one clock and an asynchronous active-high reset.
`timescale 1ns/1ps

module word_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [PTR_W:0]   count_r;
    logic             head_valid_r;
    logic [WIDTH-1:0] head_r;
    logic             push;
    logic             load;

    // Compare at full count width: a pointer-wide cast of DEPTH wraps to zero
    assign in_ready  = (count_r != (PTR_W+1)'(DEPTH));
    assign push      = in_valid & in_ready;
    // Head register refills as soon as it is empty or being taken
    assign load      = (count_r != '0) & (~head_valid_r | out_ready);
    assign out_valid = head_valid_r;
    assign out_data  = head_r;

    always_ff @(posedge mclk) begin
        if (push) begin
            store[wr_ptr_r] <= in_data;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r  <= '0;
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + PTR_W'(1);
            end
            if (load) begin
                rd_ptr_r <= rd_ptr_r + PTR_W'(1);
            end
            count_r <= count_r + (PTR_W+1)'(push) - (PTR_W+1)'(load);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            head_valid_r <= 1'b0;
            head_r       <= '0;
        end else if (load) begin
            head_valid_r <= 1'b1;
            head_r       <= store[rd_ptr_r];
        end else if (out_ready) begin
            head_valid_r <= 1'b0;
        end
    end

endmodule : word_fifo

/* File: logic/pipelined_burst_sram_port.sv */
// Pin-level port of a pipelined burst static memory with its storage array.
// Assumes the far side drives all synchronous pins from mclk; the pad ring
// resolves the data pins from dq_oe; output_enable_n and sleep_request are
// asynchronous to mclk.
//
// Overview of operation
// RQ1 - Selected only when primary select low, expand high, expand low select low.
// RQ2 - Select pins matter only in cycles that capture a new external address.
// RQ3 - Processor strobe is ignored when the primary select is high.
// RQ4 - Either strobe captures the address and loads the low bits into the counter.
// RQ5 - With both strobes low only the processor strobe is obeyed; the code obeys the controller strobe when the primary select is high.
// RQ6 - Burst step low advances the burst address to the next location.
// RQ7 - Output enable acts unclocked: low drives data pins, high floats them.
// RQ8 - First clock of a read after deselect keeps data pins floating.
// RQ9 - Read data belongs to the address captured at the preceding edge.
// RQ10 - Write data and parity are captured into an input register each edge.
// RQ11 - Sleep high idles the port and keeps contents; low means normal.
// RQ12 - Order strap low gives linear bursts, high or open gives interleaved.
// RQ13 - The system keeps the order strap steady while operating.
// RQ14 - Without a third select the port acts as if it were asserted.
// RQ15 - Burst counter is two bits and wraps over four locations.
// RQ16 - Global write low writes every lane, ignoring lane enables.
// RQ17 - Lane writes need lane enable low with the chosen lane selects low.
// RQ18 - While sleeping, commands are ignored and the data pins float.
`timescale 1ns/1ps
`include "sram_port_consts.svh"

module pipelined_burst_sram_port
    import sram_port_pkg::*;
#(
    parameter bit HAS_THIRD_SELECT = 1'b1,
    parameter int FIFO_DEPTH       = `SP_FIFO_DEPTH
) (
    input  wire logic                mclk,
    input  wire logic                rst,
    input  wire logic [`SP_ADDR_W-1:0] addr,
    input  wire logic                select_low_primary_n,
    input  wire logic                select_high_expand,
    input  wire logic                select_low_expand_n,
    input  wire logic                cpu_addr_strobe_n,
    input  wire logic                ctrl_addr_strobe_n,
    input  wire logic                burst_step_n,
    input  wire logic                all_lanes_write_n,
    input  wire logic                lane_write_enable_n,
    input  wire logic [`SP_LANES-1:0] lane_select_n,
    input  wire logic                output_enable_n,
    input  wire logic                sleep_request,
    input  wire logic                burst_order_strap,
    input  wire logic [31:0]         dq_in,
    input  wire logic [3:0]          parity_lines_in,
    output logic [31:0]              dq_out,
    output logic [3:0]               parity_lines_out,
    output logic                     dq_oe,
    output logic                     sleeping,
    output logic                     write_dropped
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [`SP_LOW_W-1:0] burst_low(
        input logic [`SP_LOW_W-1:0] start,
        input logic [`SP_LOW_W-1:0] count,
        input burst_order_e         order
    );
        if (order == ORDER_INTERLEAVED) begin
            burst_low = start ^ count;
        end else begin
            burst_low = start + count;
        end
    endfunction : burst_low

    // Data bits of lane n sit at [8n+7:8n], its parity at bit 32+n
    function automatic word_t pack_word(input logic [31:0] d, input logic [3:0] p);
        pack_word = {p, d};
    endfunction : pack_word

    // ****************************************************************
    // Asynchronous sleep input and the order strap
    // ****************************************************************
    logic         sleep_meta_r;
    logic         sleep_r;
    logic         strap_taken_r;
    burst_order_e order_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sleep_meta_r <= 1'b0;
            sleep_r      <= 1'b0;
        end else begin
            sleep_meta_r <= sleep_request;
            sleep_r      <= sleep_meta_r;
        end
    end

    // Strap caught on the first edge after reset; later changes are not seen
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            strap_taken_r <= 1'b0;
            order_r       <= burst_order_e'(`SP_STRAP_RST);
        end else if (!strap_taken_r) begin
            strap_taken_r <= 1'b1;
            order_r       <= burst_order_strap ? ORDER_INTERLEAVED : ORDER_LINEAR; // RQ12 RQ13
        end
    end

    assign sleeping = sleep_r;

    // ****************************************************************
    // Command decode
    // ****************************************************************
    logic   third_ok;
    logic   selected;
    logic   cpu_take;
    logic   ctrl_take;
    logic   new_addr;
    logic   write_req;
    lanes_t write_lanes;

    assign third_ok  = HAS_THIRD_SELECT ? ~select_low_expand_n : 1'b1; // RQ14
    assign selected  = ~select_low_primary_n & select_high_expand & third_ok; // RQ1
    assign cpu_take  = ~sleep_r & ~cpu_addr_strobe_n & ~select_low_primary_n; // RQ3 RQ18
    assign ctrl_take = ~sleep_r & ~ctrl_addr_strobe_n & ~cpu_take; // RQ5
    assign new_addr  = cpu_take | ctrl_take; // RQ4

    always_comb begin
        if (!all_lanes_write_n) begin
            write_lanes = `SP_ALL_LANES; // RQ16
        end else if (!lane_write_enable_n) begin
            write_lanes = ~lane_select_n; // RQ17
        end else begin
            write_lanes = `SP_NO_LANES;
        end
    end
    assign write_req = (write_lanes != `SP_NO_LANES);

    // ****************************************************************
    // Address register and burst counter
    // ****************************************************************
    logic                  active_r;
    addr_t                 addr_r;
    logic [`SP_LOW_W-1:0]  start_r;
    logic [`SP_LOW_W-1:0]  count_r;
    addr_t                 cur_addr;

    // Selects are looked at only inside the new_addr branch
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            active_r <= 1'b0;
            addr_r   <= '0;
            start_r  <= `SP_LOW_ZERO;
            count_r  <= `SP_LOW_ZERO;
        end else if (new_addr) begin
            active_r <= selected; // RQ1 RQ2
            addr_r   <= addr; // RQ4
            start_r  <= addr[`SP_LOW_W-1:0]; // RQ4
            count_r  <= `SP_LOW_ZERO;
        end else if (active_r && !sleep_r && !burst_step_n) begin
            count_r  <= count_r + `SP_LOW_ONE; // RQ6 RQ15
        end
    end

    assign cur_addr = {addr_r[`SP_ADDR_W-1:`SP_LOW_W], burst_low(start_r, count_r, order_r)};

    // ****************************************************************
    // Write path: input register, pending request, buffer, array
    // ****************************************************************
    word_t     in_data_r;
    wr_pend_s  pend_r;
    wr_pend_s  pend_nxt;
    wr_entry_s push_entry;
    logic      fifo_in_ready;
    logic      drain_valid;
    wr_entry_s drain_entry;
    logic      drain_ready;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            in_data_r <= '0;
        end else begin
            in_data_r <= pack_word(dq_in, parity_lines_in); // RQ10
        end
    end

    // Controller strobe writes at once; a processor strobe cycle ignores
    // write controls, its data follows in the burst cycles
    always_comb begin
        pend_nxt = '0;
        if (ctrl_take && selected && write_req) begin
            pend_nxt.valid = 1'b1;
            pend_nxt.addr  = addr;
            pend_nxt.lanes = write_lanes;
        end else if (!new_addr && active_r && !sleep_r && write_req) begin
            pend_nxt.valid = 1'b1;
            pend_nxt.addr  = cur_addr;
            pend_nxt.lanes = write_lanes;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            pend_r <= '0;
        end else begin
            pend_r <= pend_nxt; // RQ5 RQ16
        end
    end

    assign push_entry = '{addr: pend_r.addr, lanes: pend_r.lanes, data: in_data_r};
    // Array writes stall while sleeping; entries already queued wait in the buffer
    assign drain_ready = ~sleep_r; // RQ11

    word_fifo #(
        .WIDTH ($bits(wr_entry_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_write_buffer (
        .mclk      (mclk),
        .rst       (rst),
        .in_valid  (pend_r.valid),
        .in_ready  (fifo_in_ready),
        .in_data   (push_entry),
        .out_valid (drain_valid),
        .out_ready (drain_ready),
        .out_data  (drain_entry)
    );

    // A full buffer cannot push back on the pins; the write is lost and flagged
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            write_dropped <= 1'b0;
        end else begin
            write_dropped <= pend_r.valid & ~fifo_in_ready;
        end
    end

    word_t array_r [2**`SP_ADDR_W];

    always_ff @(posedge mclk) begin
        if (drain_valid && drain_ready) begin
            for (int n = 0; n < `SP_LANES; n++) begin
                if (drain_entry.lanes[n]) begin
                    array_r[drain_entry.addr][n*`SP_BYTE_W +: `SP_BYTE_W] <=
                        drain_entry.data[n*`SP_BYTE_W +: `SP_BYTE_W];
                    array_r[drain_entry.addr][32+n] <= drain_entry.data[32+n];
                end
            end
        end
    end

    // ****************************************************************
    // Read path and output drive
    // ****************************************************************
    // Reads see the array only; a write still queued is not forwarded
    word_t dout_r;
    logic  drive_r;
    logic  first_r;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            dout_r <= '0;
        end else if (active_r) begin
            dout_r <= array_r[cur_addr]; // RQ9
        end
    end

    assign dq_out           = dout_r[31:0];
    assign parity_lines_out = dout_r[35:32];

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            drive_r <= 1'b0;
            first_r <= 1'b0;
        end else if (sleep_r) begin
            drive_r <= 1'b0; // RQ18
            first_r <= 1'b0;
        end else if (new_addr) begin
            drive_r <= selected & ~(ctrl_take & write_req);
            first_r <= selected & ~active_r; // RQ8
        end else if (active_r) begin
            drive_r <= ~write_req;
            first_r <= 1'b0;
        end else begin
            drive_r <= 1'b0;
            first_r <= 1'b0;
        end
    end

    // Enable is gated without a clock so the turnaround follows the pin
    assign dq_oe = drive_r & ~first_r & ~output_enable_n & ~sleep_r; // RQ7 RQ8 RQ11

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence deselected_s;
        !active_r;
    endsequence
    sequence read_capture_s;
        new_addr && selected && !(ctrl_take && write_req);
    endsequence

    sel_decode_a: assert property (new_addr |=> active_r == $past(selected)) // RQ1
        else $error("selection does not follow the three selects");
    burst_hold_a: assert property (active_r && !new_addr |=> active_r) // RQ2
        else $error("selection changed without an address capture");
    cpu_gate_a: assert property (!cpu_addr_strobe_n && select_low_primary_n
        && ctrl_addr_strobe_n |=> $stable(active_r) && $stable(addr_r)) // RQ3
        else $error("processor strobe obeyed with primary select high");
    addr_load_a: assert property (new_addr |=> start_r == $past(addr[1:0])
        && count_r == 2'h0) // RQ4
        else $error("strobe did not load address low bits");
    strobe_prio_a: assert property (!sleep_r && !cpu_addr_strobe_n
        && !ctrl_addr_strobe_n && !select_low_primary_n |=> !pend_r.valid) // RQ5
        else $error("controller strobe acted beside processor strobe");
    burst_step_a: assert property (active_r && !new_addr && !sleep_r && !burst_step_n
        |=> count_r == $past(count_r) + 2'h1) // RQ6 RQ15
        else $error("burst counter did not step");
    oe_float_a: assert property (output_enable_n |-> !dq_oe) // RQ7
        else $error("data pins driven with output enable high");
    first_mask_a: assert property (deselected_s ##0 read_capture_s |=> !dq_oe) // RQ8
        else $error("first read cycle after deselect drove the pins");
    all_lanes_a: assert property (pend_nxt.valid && !all_lanes_write_n
        |=> pend_r.lanes == 4'hf) // RQ16
        else $error("global write did not take all lanes");
    sleep_quiet_a: assert property (sleep_r |-> !dq_oe ##1 !pend_r.valid) // RQ18
        else $error("port active while sleeping");

endmodule : pipelined_burst_sram_port

/* File: tb/bus_controller_model.sv */
// Far-side bus controller model driving every synchronous pin of the memory port.
// Assumes the bench resolves the data pins from dq_oe and calls these tasks.
`timescale 1ns/1ps

module bus_controller_model
    import sram_port_pkg::*;
(
    input  wire logic   mclk,
    output addr_t       addr,
    output logic        select_low_primary_n,
    output logic        select_high_expand,
    output logic        select_low_expand_n,
    output logic        cpu_addr_strobe_n,
    output logic        ctrl_addr_strobe_n,
    output logic        burst_step_n,
    output logic        all_lanes_write_n,
    output logic        lane_write_enable_n,
    output lanes_t      lane_select_n,
    output logic        output_enable_n,
    output logic        sleep_request,
    output logic        burst_order_strap,
    output logic [31:0] dq_drv,
    output logic [3:0]  parity_drv
);
    // Pins move a fixed delay after the edge, never on it
    task automatic tick();
        @(posedge mclk);
        #2;
    endtask : tick

    task automatic idle();
        cpu_addr_strobe_n    = 1'b1;
        ctrl_addr_strobe_n   = 1'b1;
        burst_step_n         = 1'b1;
        all_lanes_write_n    = 1'b1;
        lane_write_enable_n  = 1'b1;
        lane_select_n        = 4'hf;
        select_low_primary_n = 1'b0;
        select_high_expand   = 1'b1;
        // Released lines show the inverse so a stale word cannot pass
        dq_drv               = ~dq_drv;
        parity_drv           = ~parity_drv;
    endtask : idle

    // Strap changes only while the port is held in reset
    task automatic power_up(input logic order);
        burst_order_strap = order;
    endtask : power_up

    task automatic capture(input logic cpu_n, input logic ctrl_n, input logic prim_n,
                           input addr_t a, input logic all_n, input lanes_t lane_n,
                           input logic [35:0] d);
        addr                 = a;
        cpu_addr_strobe_n    = cpu_n;
        ctrl_addr_strobe_n   = ctrl_n;
        select_low_primary_n = prim_n;
        select_high_expand   = 1'b1;
        burst_step_n         = 1'b1;
        all_lanes_write_n    = all_n;
        lane_select_n        = lane_n;
        lane_write_enable_n  = &lane_n;
        // Pins are handed to the port only for reads, so write data is not overdriven
        output_enable_n      = ~all_n | ~(&lane_n);
        {parity_drv, dq_drv} = d;
        tick();
    endtask : capture

    task automatic step(input logic spoil);
        cpu_addr_strobe_n    = 1'b1;
        ctrl_addr_strobe_n   = 1'b1;
        all_lanes_write_n    = 1'b1;
        lane_write_enable_n  = 1'b1;
        burst_step_n         = 1'b0;
        select_low_primary_n = spoil;
        select_high_expand   = ~spoil;
        tick();
    endtask : step

    task automatic set_oe(input logic v);
        output_enable_n = v;
    endtask : set_oe

    task automatic set_sleep(input logic v);
        sleep_request = v;
    endtask : set_sleep

    task automatic set_third(input logic v);
        select_low_expand_n = v;
    endtask : set_third

    initial begin
        addr                = 18'h0_0000;
        select_low_expand_n = 1'b0;
        output_enable_n     = 1'b0;
        sleep_request       = 1'b0;
        dq_drv              = 32'h0000_0000;
        parity_drv          = 4'h0;
        idle();
    end
endmodule : bus_controller_model

/* File: tb/testbench.sv */
// Self-checking bench for the burst memory port and its word buffer.
// Assumes the design package, the design modules and the bus model compile first.
`timescale 1ns/1ps

module testbench;
    import sram_port_pkg::*;

    logic mclk, rst;
    addr_t addr;
    lanes_t lane_select_n;
    logic select_low_primary_n, select_high_expand, select_low_expand_n;
    logic cpu_addr_strobe_n, ctrl_addr_strobe_n, burst_step_n, all_lanes_write_n;
    logic lane_write_enable_n, output_enable_n, sleep_request, burst_order_strap;
    logic [31:0] dq_in, dq_out, dq_drv;
    logic [3:0] parity_lines_in, parity_lines_out, parity_drv;
    logic dq_oe, sleeping, write_dropped;
    int n_errors = 0;
    int compares = 0;
    addr_t base = 18'h0_00a4;

    // The pad ring: whoever is enabled owns the data lines
    assign dq_in = dq_oe ? dq_out : dq_drv;
    assign parity_lines_in = dq_oe ? parity_lines_out : parity_drv;

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    bus_controller_model bus_controller_model_inst (.mclk, .addr, .select_low_primary_n,
        .select_high_expand, .select_low_expand_n, .cpu_addr_strobe_n, .ctrl_addr_strobe_n,
        .burst_step_n, .all_lanes_write_n, .lane_write_enable_n, .lane_select_n,
        .output_enable_n, .sleep_request, .burst_order_strap, .dq_drv, .parity_drv);

    pipelined_burst_sram_port #(.FIFO_DEPTH(32)) pipelined_burst_sram_port_inst (.mclk,
        .rst, .addr, .select_low_primary_n, .select_high_expand, .select_low_expand_n,
        .cpu_addr_strobe_n, .ctrl_addr_strobe_n, .burst_step_n, .all_lanes_write_n,
        .lane_write_enable_n, .lane_select_n, .output_enable_n, .sleep_request,
        .burst_order_strap, .dq_in, .parity_lines_in, .dq_out, .parity_lines_out, .dq_oe,
        .sleeping, .write_dropped);

    function automatic logic [35:0] pat(input addr_t a);
        return {a[3:0], a[15:0], ~a[15:0]};
    endfunction : pat

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_flag(input logic got, input logic exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_flag

    task automatic tk();
        bus_controller_model_inst.idle();
        bus_controller_model_inst.tick();
    endtask : tk

    // ctl is {processor strobe, controller strobe, primary select}, all active low
    task automatic cap(input logic [2:0] ctl, input addr_t a, input logic all_n,
                       input lanes_t ln, input logic [35:0] d);
        bus_controller_model_inst.capture(ctl[2], ctl[1], ctl[0], a, all_n, ln, d);
    endtask : cap

    task automatic rd_chk(input addr_t a, input logic [35:0] e);
        cap(3'b010, a, 1'b1, 4'hf, 36'h0_0000_0000);
        tk();
        chk_word({parity_lines_out, dq_out}, e);
    endtask : rd_chk

    task automatic do_reset(input logic ord);
        rst = 1'b1;
        bus_controller_model_inst.power_up(ord);
        repeat (2) @(posedge mclk);
        #2;
        rst = 1'b0;
        chk_flag(dq_oe, 1'b0);
        chk_flag(sleeping, 1'b0);
        chk_flag(write_dropped, 1'b0);
        chk_word({parity_lines_out, dq_out}, 36'h0_0000_0000);
        tk();
        tk();
        $display("test reset done");
    endtask : do_reset

    task automatic t_write_all();
        for (int i = 0; i < 4; i++) begin
            cap(3'b100, base + 18'(i), 1'b0, 4'hf, pat(base + 18'(i)));
        end
        repeat (4) tk();
        $display("test write_all done");
    endtask : t_write_all

    task automatic t_burst(input logic ord);
        logic [1:0] s;
        cap(3'b101, base, 1'b1, 4'hf, 36'h0_0000_0000);
        cap(3'b010, base + 18'h0_0001, 1'b1, 4'hf, 36'h0_0000_0000);
        chk_flag(dq_oe, 1'b0);
        for (int i = 0; i < 5; i++) begin
            s = ord ? (2'h1 ^ 2'(i)) : (2'h1 + 2'(i));
            bus_controller_model_inst.step(i == 2);
            chk_word({parity_lines_out, dq_out}, pat(base + 18'(s)));
        end
        chk_flag(dq_oe, 1'b1);
        bus_controller_model_inst.set_oe(1'b1);
        #1;
        chk_flag(dq_oe, 1'b0);
        bus_controller_model_inst.set_oe(1'b0);
        #1;
        chk_flag(dq_oe, 1'b1);
        $display("test burst done");
    endtask : t_burst

    task automatic t_strobes();
        bus_controller_model_inst.set_third(1'b1);
        cap(3'b010, base, 1'b1, 4'hf, 36'h0_0000_0000);
        chk_flag(dq_oe, 1'b0);
        bus_controller_model_inst.set_third(1'b0);
        rd_chk(base, pat(base));
        cap(3'b011, base + 18'h0_0003, 1'b1, 4'hf, 36'h0_0000_0000);
        tk();
        chk_word({parity_lines_out, dq_out}, pat(base));
        cap(3'b000, base + 18'h0_0002, 1'b0, 4'hf, ~pat(base + 18'h0_0002));
        repeat (4) tk();
        rd_chk(base + 18'h0_0002, pat(base + 18'h0_0002));
        $display("test strobes done");
    endtask : t_strobes

    task automatic t_lane();
        logic [35:0] e;
        e = pat(base + 18'h0_0003);
        cap(3'b100, base + 18'h0_0003, 1'b1, 4'he, ~e);
        repeat (4) tk();
        rd_chk(base + 18'h0_0003, {e[35:33], ~e[32], e[31:8], ~e[7:0]});
        $display("test lane done");
    endtask : t_lane

    task automatic t_sleep();
        bus_controller_model_inst.set_sleep(1'b1);
        tk();
        tk();
        chk_flag(sleeping, 1'b1);
        chk_flag(dq_oe, 1'b0);
        cap(3'b100, base, 1'b0, 4'hf, ~pat(base));
        bus_controller_model_inst.set_sleep(1'b0);
        for (int n = 0; n < 8 && sleeping !== 1'b0; n++) begin
            tk();
        end
        if (sleeping !== 1'b0) begin
            n_errors++;
            complete_run();
        end
        repeat (4) tk();
        rd_chk(base, pat(base));
        $display("test sleep done");
    endtask : t_sleep

    // A long back-to-back write stream wraps the buffer pointers inside the port
    task automatic t_fifo();
        for (int i = 0; i < 40; i++) begin
            cap(3'b100, 18'h0_1000 + 18'(i), 1'b0, 4'hf, pat(18'h0_1000 + 18'(i)));
            chk_flag(write_dropped, 1'b0);
        end
        repeat (4) tk();
        for (int i = 0; i < 40; i++) begin
            rd_chk(18'h0_1000 + 18'(i), pat(18'h0_1000 + 18'(i)));
        end
        $display("test fifo done");
    endtask : t_fifo

    initial begin
        for (int o = 0; o < 2; o++) begin
            do_reset(o[0]);
            t_write_all();
            t_burst(o[0]);
        end
        t_strobes();
        t_lane();
        t_sleep();
        t_fifo();
        complete_run();
    end
endmodule : testbench
